// File: verilog/mem_test_pkg.sv
// constants and carriers for the memory throughput test sequencer
// assumes a single clock domain shared by uart, axi master and count memory
package mem_test_pkg;
  // ===========================================================================
  // host link bytes
  localparam logic [7:0] HANDSHAKE_BYTE = 8'h63;
  localparam logic [7:0] ACK_BYTE       = 8'h61;
  localparam logic [3:0] OP_WRITE       = 4'h1;
  localparam logic [3:0] OP_READ        = 4'h2;
  // ===========================================================================
  // transfer geometry
  localparam int REPEATS        = 8;
  localparam int BEATS_PER_BURST = 16;
  localparam int BYTES_PER_BEAT = 8;
  localparam int BURST_BYTES    = BEATS_PER_BURST * BYTES_PER_BEAT;
  localparam int MIN_XFER_BYTES = 2048;
  localparam int MIN_BURSTS     = MIN_XFER_BYTES / BURST_BYTES;
  localparam int BANK_LSB       = 14;
  localparam int ROW_LSB        = 16;
  localparam int COUNT_W        = 16;
  localparam int FIFO_DEPTH     = 8;
  localparam logic [31:0] SDRAM_BASE = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACK    = 3'b001,
    ST_CMD    = 3'b011,
    ST_RUN    = 3'b010,
    ST_REPORT = 3'b110,
    ST_DRAIN  = 3'b111
  } seq_state_type;

  typedef struct packed {
    logic        write;     // 1: block ram to sdram, 0: sdram to block ram
    logic [31:0] sdram_addr;
    logic [15:0] bram_addr;
    logic [7:0]  beats;
  } burst_req_type;

  typedef struct packed {
    logic [2:0]         addr;
    logic [COUNT_W-1:0] count;
  } count_store_type;
endpackage

// File: verilog/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active high reset
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gen_bad_params
    $error("byte_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                            (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty = (wr_ptr_reg == rd_ptr_reg);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// File: verilog/mem_test_sequencer.sv
// command interpreter and transfer sequencer for the memory throughput test
// assumes uart byte streams, burst engine and memory controller on i_ref_clk
`timescale 1ns/1ps
module mem_test_sequencer (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_reset,
  input  wire logic                           i_rx_valid,
  input  wire logic [7:0]                     i_rx_data,
  output logic                                o_tx_valid,
  input  wire logic                           i_tx_ready,
  output logic      [7:0]                     o_tx_data,
  output logic                                o_burst_valid,
  input  wire logic                           i_burst_ready,
  output mem_test_pkg::burst_req_type         o_burst,
  input  wire logic                           i_burst_done,
  output logic                                o_count_valid,
  output mem_test_pkg::count_store_type       o_count,
  output logic                                o_busy
);
  localparam int CW = mem_test_pkg::COUNT_W;

  // ===========================================================================
  // state and counters
  mem_test_pkg::seq_state_type state_reg, state_next;
  logic             wrote_reg;
  logic             dir_write_reg;
  logic [1:0]       size_code_reg;
  logic [7:0]       issued_reg;
  logic [7:0]       done_reg;
  logic [2:0]       rep_reg;
  logic [CW-1:0]    cycle_reg;
  logic [3:0]       byte_idx_reg;
  logic [CW-1:0]    count_mem [mem_test_pkg::REPEATS];
  logic             count_valid_reg;
  mem_test_pkg::count_store_type count_reg;

  // ===========================================================================
  // decode
  wire       rx_handshake = i_rx_valid && (i_rx_data == mem_test_pkg::HANDSHAKE_BYTE);
  wire [3:0] rx_op        = i_rx_data[7:4];
  wire       cmd_ok       = i_rx_valid &&
                            (wrote_reg ? (rx_op == mem_test_pkg::OP_READ)
                                       : (rx_op == mem_test_pkg::OP_WRITE));
  wire [7:0] total_bursts = 8'(mem_test_pkg::MIN_BURSTS) << size_code_reg;
  wire       issue        = (state_reg == mem_test_pkg::ST_RUN) && (issued_reg < total_bursts);
  wire       issue_fire   = issue && i_burst_ready;
  wire       rep_end      = (state_reg == mem_test_pkg::ST_RUN) && i_burst_done &&
                            (done_reg == total_bursts - 8'h01);
  wire       last_rep     = (rep_reg == 3'(mem_test_pkg::REPEATS - 1));
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       fifo_push    = (state_reg == mem_test_pkg::ST_REPORT);
  wire [CW-1:0] rpt_word  = count_mem[byte_idx_reg[3:1]];
  wire [7:0] rpt_byte     = byte_idx_reg[0] ? rpt_word[7:0] : rpt_word[15:8];
  wire       push_fire    = fifo_push && fifo_in_ready;
  wire       in_ack       = (state_reg == mem_test_pkg::ST_ACK);
  wire [31:0] rep_base    = mem_test_pkg::SDRAM_BASE |
                            (32'(rep_reg[1:0]) << mem_test_pkg::BANK_LSB) |
                            (32'(rep_reg[2]) << mem_test_pkg::ROW_LSB);
  wire [31:0] burst_off   = 32'(issued_reg) * 32'(mem_test_pkg::BURST_BYTES);

  // ===========================================================================
  // outputs
  assign o_tx_valid    = in_ack || fifo_out_valid;
  assign o_tx_data     = in_ack ? mem_test_pkg::ACK_BYTE : fifo_out_data;
  assign o_burst_valid = issue;
  assign o_burst.write      = dir_write_reg;
  assign o_burst.sdram_addr = rep_base + burst_off;
  assign o_burst.bram_addr  = burst_off[15:0];
  assign o_burst.beats      = 8'(mem_test_pkg::BEATS_PER_BURST);
  assign o_count_valid = count_valid_reg;
  assign o_count       = count_reg;
  assign o_busy        = (state_reg == mem_test_pkg::ST_RUN);

  // ===========================================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mem_test_pkg::ST_IDLE: begin
        if (rx_handshake)
          state_next = mem_test_pkg::ST_ACK;
      end
      mem_test_pkg::ST_ACK: begin
        if (i_tx_ready)
          state_next = mem_test_pkg::ST_CMD;
      end
      mem_test_pkg::ST_CMD: begin
        if (cmd_ok)
          state_next = mem_test_pkg::ST_RUN;
        else if (i_rx_valid)
          state_next = mem_test_pkg::ST_IDLE;
      end
      mem_test_pkg::ST_RUN: begin
        if (rep_end && last_rep)
          state_next = mem_test_pkg::ST_REPORT;
      end
      mem_test_pkg::ST_REPORT: begin
        if (push_fire && byte_idx_reg == 4'hf)
          state_next = mem_test_pkg::ST_DRAIN;
      end
      mem_test_pkg::ST_DRAIN: begin
        if (!fifo_out_valid)
          state_next = mem_test_pkg::ST_IDLE;
      end
      default: state_next = mem_test_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg     <= mem_test_pkg::ST_IDLE;
      wrote_reg     <= 1'b0;
      dir_write_reg <= 1'b0;
      size_code_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == mem_test_pkg::ST_CMD && cmd_ok) begin
        dir_write_reg <= !wrote_reg;
        size_code_reg <= i_rx_data[1:0];
      end
      if (rep_end && last_rep)
        wrote_reg <= dir_write_reg;
    end
  end

  // burst bookkeeping and per-repetition clock count
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      issued_reg <= 8'h00;
      done_reg   <= 8'h00;
      rep_reg    <= 3'h0;
      cycle_reg  <= mem_test_pkg::COUNT_RESET;
    end else if (state_reg != mem_test_pkg::ST_RUN) begin
      issued_reg <= 8'h00;
      done_reg   <= 8'h00;
      rep_reg    <= 3'h0;
      cycle_reg  <= mem_test_pkg::COUNT_RESET;
    end else if (rep_end) begin
      issued_reg <= 8'h00;
      done_reg   <= 8'h00;
      rep_reg    <= rep_reg + 3'h1;
      cycle_reg  <= mem_test_pkg::COUNT_RESET;
    end else begin
      if (issue_fire)
        issued_reg <= issued_reg + 8'h01;
      if (i_burst_done)
        done_reg <= done_reg + 8'h01;
      cycle_reg <= cycle_reg + 1'b1;
    end
  end

  // count memory and hand-off to the command interface
  always_ff @(posedge i_ref_clk) begin
    if (rep_end)
      count_mem[rep_reg] <= cycle_reg + 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      count_valid_reg <= 1'b0;
      count_reg       <= '0;
      byte_idx_reg    <= 4'h0;
    end else begin
      count_valid_reg <= rep_end;
      if (rep_end) begin
        count_reg.addr  <= rep_reg;
        count_reg.count <= cycle_reg + 1'b1;
      end
      if (state_reg != mem_test_pkg::ST_REPORT)
        byte_idx_reg <= 4'h0;
      else if (push_fire)
        byte_idx_reg <= byte_idx_reg + 4'h1;
    end
  end

  // ===========================================================================
  // report buffer towards the uart transmitter
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (mem_test_pkg::FIFO_DEPTH)
  ) u_report_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (rpt_byte),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_tx_ready && !in_ack),
    .o_out_data  (fifo_out_data)
  );

  // ===========================================================================
  // checks
  sequence hs_seen;
    state_reg == mem_test_pkg::ST_IDLE && rx_handshake;
  endsequence
  sequence ack_sent;
    o_tx_valid && o_tx_data == mem_test_pkg::ACK_BYTE;
  endsequence

  chk_handshake_ack: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hs_seen |=> ack_sent) else $error("no acknowledge after handshake");
  chk_run_needs_hs: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(o_busy) |-> $past(state_reg) == mem_test_pkg::ST_CMD)
    else $error("transfer started without command phase");
  chk_read_after_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (o_burst_valid && !o_burst.write) |-> wrote_reg)
    else $error("read test before write test");
  chk_burst_beats: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_burst_valid |-> o_burst.beats == 8'd16) else $error("burst is not 16 beats");
  chk_rows_banks: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_burst_valid |-> o_burst.sdram_addr[mem_test_pkg::BANK_LSB +: 2] == rep_reg[1:0] &&
                      o_burst.sdram_addr[mem_test_pkg::ROW_LSB] == rep_reg[2])
    else $error("burst address outside row or bank");
  chk_count_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (o_count_valid && o_count.addr != 3'h0) |->
      o_count.addr == $past(o_count.addr) + 3'h1)
    else $error("count address does not advance");
  chk_count_value: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    rep_end |=> o_count_valid && o_count.count == $past(cycle_reg) + 16'h0001)
    else $error("count does not match elapsed clocks");
  chk_eight_reps: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (rep_end && rep_reg != 3'h7) |=> state_reg == mem_test_pkg::ST_RUN)
    else $error("test ended before eight transfers");
  chk_report_after: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (rep_end && last_rep) |=> state_reg == mem_test_pkg::ST_REPORT ##1
      fifo_out_valid) else $error("counts not reported after test");
  chk_issue_limit: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_burst_valid |-> issued_reg < total_bursts) else $error("too many bursts");
endmodule

// File: tb/host_link_model.sv
// host side of the uart byte link: sends command bytes, collects sent bytes
// assumes one clock; byte strobes last a single cycle
`timescale 1ns/1ps
module host_link_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_slow,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] got_q[$];
  int         phase;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b1;
    phase      = 0;
  end

  // ==========================================================================
  // receive side, slow mode takes one byte in three cycles
  always @(negedge i_ref_clk) begin
    phase = (phase + 1) % 3;
    o_tx_ready = !i_slow || (phase == 0);
  end

  always @(posedge i_ref_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      got_q.push_back(i_tx_data);
    end
  end

  // ==========================================================================
  // send side, idle data line shows the inverse of the last byte
  task automatic send_byte(input logic [7:0] b);
    @(negedge i_ref_clk);
    o_rx_valid = 1'b1;
    o_rx_data  = b;
    @(negedge i_ref_clk);
    o_rx_valid = 1'b0;
    o_rx_data  = ~b;
  endtask
endmodule

// File: tb/mem_test_sequencer_tb.sv
// self-checking bench for the memory test sequencer
// assumes host_link_model on the uart side; burst engine modelled here
`timescale 1ns/1ps
module mem_test_sequencer_tb;
  logic                          ref_clk, reset, burst_ready, burst_done;
  logic                          slow_host, cmd_armed, write_exp;
  logic                          rx_valid, tx_valid, tx_ready, burst_valid;
  logic                          count_valid, busy;
  logic [7:0]                    rx_data, tx_data;
  mem_test_pkg::burst_req_type   burst;
  mem_test_pkg::count_store_type count;
  int                            miscompares, n_compared, cyc, ref_cyc, last_done;
  int                            nb, ndone, ncount, per_rep, rep, off;
  int                            done_q[$], exp_q[$];

  mem_test_sequencer u_mem_test_sequencer (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data),
    .o_burst_valid(burst_valid), .i_burst_ready(burst_ready), .o_burst(burst),
    .i_burst_done(burst_done), .o_count_valid(count_valid), .o_count(count),
    .o_busy(busy));

  host_link_model u_host_link_model (
    .i_ref_clk(ref_clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_slow(slow_host),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // burst engine: stalls one cycle in four, done after a varying delay
  always @(negedge ref_clk) begin
    burst_ready = (cyc % 4) != 1;
    burst_done = (done_q.size() > 0) && (done_q[0] == cyc + 1);
    if (burst_done) void'(done_q.pop_front());
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (rx_valid && cmd_armed) ref_cyc = cyc;
    if (burst_valid && burst_ready) begin
      rep = nb / per_rep;
      off = nb % per_rep;
      cmp_bit(ndone >= rep * per_rep, 1'b1);
      cmp_word(burst.sdram_addr, mem_test_pkg::SDRAM_BASE + 32'(off * 128)
        + (32'(rep / 4) << mem_test_pkg::ROW_LSB)
        + (32'(rep % 4) << mem_test_pkg::BANK_LSB));
      cmp_word(32'(burst.bram_addr), 32'(off * 128));
      cmp_word(32'(burst.beats), 32'(mem_test_pkg::BEATS_PER_BURST));
      cmp_bit(burst.write, write_exp);
      nb++;
      last_done = (cyc + 2 + nb % 3 > last_done) ? cyc + 2 + nb % 3 : last_done + 1;
      done_q.push_back(last_done);
    end
    if (burst_done) begin
      ndone++;
      if (ndone % per_rep == 0) begin
        exp_q.push_back(cyc - ref_cyc);
        ref_cyc = cyc;
      end
    end
    if (count_valid) begin
      cmp_word(32'(count.addr), 32'(ncount % 8));
      cmp_word(32'(count.count), exp_q.size() > ncount ? exp_q[ncount] : -1);
      ncount++;
    end
  end

  // ==========================================================================
  // scenarios
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 40000 && u_host_link_model.got_q.size() < n; i++) @(negedge ref_clk);
  endtask

  task automatic handshake();
    u_host_link_model.got_q.delete();
    u_host_link_model.send_byte(mem_test_pkg::HANDSHAKE_BYTE);
    wait_bytes(1);
    cmp_word(32'(u_host_link_model.got_q.size()), 32'd1);
    cmp_word(32'(u_host_link_model.got_q[0]), 32'(mem_test_pkg::ACK_BYTE));
    u_host_link_model.got_q.delete();
  endtask

  task automatic run_test(input logic [3:0] op, input int size);
    per_rep = 16 << size;
    write_exp = (op == mem_test_pkg::OP_WRITE);
    nb = 0;
    ndone = 0;
    ncount = 0;
    exp_q.delete();
    handshake();
    cmd_armed = 1'b1;
    u_host_link_model.send_byte({op, 2'b00, 2'(size)});
    cmd_armed = 1'b0;
    cmp_bit(busy, 1'b1);
    u_host_link_model.send_byte(mem_test_pkg::HANDSHAKE_BYTE);
    wait_bytes(16);
    repeat (6) @(negedge ref_clk);
    cmp_word(32'(nb), 32'(8 * per_rep));
    cmp_word(32'(ncount), 32'd8);
    cmp_word(32'(u_host_link_model.got_q.size()), 32'd16);
    for (int i = 0; i < 8; i++) begin
      cmp_word(32'(u_host_link_model.got_q[2 * i]), 32'(exp_q[i] >> 8 & 255));
      cmp_word(32'(u_host_link_model.got_q[2 * i + 1]), 32'(exp_q[i] & 255));
    end
    cmp_bit(busy, 1'b0);
  endtask

  task automatic test_reset();
    repeat (3) @(negedge ref_clk);
    cmp_bit(tx_valid | burst_valid | count_valid | busy, 1'b0);
    cmp_word(32'(count), 32'd0);
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    $display("test reset done");
  endtask

  task automatic test_idle_ignore();
    u_host_link_model.send_byte(mem_test_pkg::ACK_BYTE);
    u_host_link_model.send_byte(8'h10);
    repeat (6) @(negedge ref_clk);
    cmp_word(32'(u_host_link_model.got_q.size()), 32'd0);
    cmp_bit(busy, 1'b0);
    $display("test idle ignore done");
  endtask

  task automatic test_read_first();
    per_rep = 16;
    nb = 0;
    handshake();
    u_host_link_model.send_byte(8'h20);
    repeat (8) @(negedge ref_clk);
    cmp_bit(busy, 1'b0);
    cmp_word(32'(nb), 32'd0);
    $display("test read first done");
  endtask

  task automatic test_sizes();
    for (int s = 0; s < 4; s++) begin
      slow_host = s[0];
      run_test(s[0] ? mem_test_pkg::OP_READ : mem_test_pkg::OP_WRITE, s);
    end
    $display("test sizes done");
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    {reset, slow_host, cmd_armed, write_exp} = 4'h8;
    {miscompares, n_compared, cyc, ref_cyc, last_done, nb, ndone, ncount} = '0;
    per_rep = 16;
    test_reset();
    test_idle_ignore();
    test_read_first();
    test_sizes();
    stop_test();
  end

  initial begin
    #(400000);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
